// File: common/arct_pkg.sv
/*
  Constants for the auto-reload capture timer: Wishbone register offsets,
  field positions, reset values and mode encodings.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package arct_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_RELOAD  = 8'h08;
  localparam logic [7:0] ADDR_COMPARE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;

  // Control register fields.
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_SSHOT    = 1;
  localparam int CTRL_GATE     = 2;
  localparam int CTRL_CPRL     = 3;
  localparam int CTRL_SPLIT    = 4;
  localparam int CTRL_IRQ_EN   = 5;
  localparam int CTRL_OE0      = 6;
  localparam int CTRL_OE1      = 7;
  localparam int CTRL_POL0     = 8;
  localparam int CTRL_POL1     = 9;
  localparam int CTRL_EDGE_LSB = 10;
  localparam int CTRL_DIV_LSB  = 12;

  // Status register fields.
  localparam int STAT_OVF = 0;
  localparam int STAT_CMP = 1;
  localparam int STAT_IRQ = 2;
  localparam int STAT_OCK = 3;

  localparam logic [14:0] CTRL_RESET  = 15'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP   = 16'hFFFF;

  localparam logic [1:0] EDGE_NONE    = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;
endpackage

// File: hdl/arct_timer.sv
/*
  Auto-reload 16-bit timer with compare/PWM and edge capture, Wishbone slave.
  Assumes pin inputs are asynchronous and a single 200 MHz clock domain.
*/
// The register addresses and the Wishbone slave port were decided locally.
// Contract
// - Split bit and edge field zero select 16-bit auto-reload compare timer.
// - Count on system clock divided by two to the power of the prescale field, only while running.
// - On overflow load the reload value, then keep counting up.
// - Set overflow flag at all ones; request interrupt when enabled.
// - Compare mode sets compare flag on match; interrupt when enabled.
// - Compare values outside reload-to-top range never match.
// - Output clock toggles after match or overflow; once when both coincide.
// - Two enables route output clock to primary and secondary pins.
// - Pin output is output clock XOR its polarity bit.
// - Polarity takes effect only on enable rising from zero to one.
// - Gating needs gate enable set and primary output disabled.
// - Gated timer clock blocks while primary pin equals primary polarity.
// - Single shot runs timer until overflow, then self-clears.
// - Single shot with run set keeps running after overflow.
// - Gated single shot starts on gate removal, may span gated intervals.
// - Edge field: 1 rising, 2 falling, 3 both edges capture.
// - Capture-reload bit reloads on capture edges; ignored in compare mode.
// - Capture mode drives no output waveform on the pins.
// - Single-edge gated capture blocks clock at primary polarity level.
// - Gated both-edge capture-reload: polarity picks capture-only edge.
// - Capture single shot starts on edge, runs until the next start edge, no start flag.
// - Both-edge single shot: polarity one uses falling edge, zero rising.
`timescale 1ns/1ps
module arct_timer #(
  parameter int DUAL_PIN = 1
) (
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Wishbone slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Pins.
  input  wire logic        primary_pin_in,
  output logic             primary_pin_out,
  output logic             primary_pin_oe_out,
  output logic             secondary_pin_out,
  output logic             secondary_pin_oe_out,
  // Interrupt request level.
  output logic             timer_irq_out
);
  logic [14:0] ctrl;
  logic [15:0] count_value;
  logic [15:0] reload;
  logic [15:0] compare;
  logic        overflow_flag;
  logic        compare_status_flag;
  logic        out_clk;
  logic [1:0]  pol_live;
  logic [1:0]  oe_q;
  logic [2:0]  pin_sync;
  logic [6:0]  pre_cnt;
  logic        ss_armed;
  logic        ss_started;

  logic        run_bit, single_shot_bit, gate_enable, capture_reload_enable, timer_irq_enable;
  logic [1:0]  pin_output_enables, pin_polarity, capture_edge_select;
  logic [2:0]  prescale_select;
  logic        capture_mode, compare_mode;
  assign run_bit               = ctrl[arct_pkg::CTRL_RUN];
  assign single_shot_bit       = ctrl[arct_pkg::CTRL_SSHOT];
  assign gate_enable           = ctrl[arct_pkg::CTRL_GATE];
  assign capture_reload_enable = ctrl[arct_pkg::CTRL_CPRL];
  assign timer_irq_enable      = ctrl[arct_pkg::CTRL_IRQ_EN];
  assign pin_output_enables    = {ctrl[arct_pkg::CTRL_OE1] & (DUAL_PIN != 0), ctrl[arct_pkg::CTRL_OE0]};
  assign pin_polarity          = {ctrl[arct_pkg::CTRL_POL1], ctrl[arct_pkg::CTRL_POL0]};
  assign capture_edge_select   = ctrl[arct_pkg::CTRL_EDGE_LSB +: 2];
  assign prescale_select       = ctrl[arct_pkg::CTRL_DIV_LSB +: 3];
  // Split mode is not built; with the split bit set the counter still runs, but nothing matches, captures or drives a pin.
  assign compare_mode = !ctrl[arct_pkg::CTRL_SPLIT] && capture_edge_select == arct_pkg::EDGE_NONE;
  assign capture_mode = !ctrl[arct_pkg::CTRL_SPLIT] && capture_edge_select != arct_pkg::EDGE_NONE;

  // Pin synchroniser; only the second and third stages feed logic.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], primary_pin_in};
    end
  end

  logic pin_lvl, rise, fall;
  assign pin_lvl = pin_sync[1];
  assign rise = pin_sync[1] & ~pin_sync[2];
  assign fall = ~pin_sync[1] & pin_sync[2];

  logic gating, gate_blocked;
  assign gating       = gate_enable && !pin_output_enables[0];
  assign gate_blocked = gating && (pin_lvl == pin_polarity[0]);

  // Edge qualification for capture and reload.
  logic cap_edge, start_edge, reload_edge;
  always_comb begin
    cap_edge   = 1'b0;
    start_edge = 1'b0;
    case (capture_edge_select)
      arct_pkg::EDGE_RISE: begin
        cap_edge   = rise;
        start_edge = rise;
      end
      arct_pkg::EDGE_FALL: begin
        cap_edge   = fall;
        start_edge = fall;
      end
      arct_pkg::EDGE_BOTH: begin
        cap_edge   = rise | fall;
        start_edge = pin_polarity[0] ? fall : rise;
      end
      default: begin
        cap_edge   = 1'b0;
        start_edge = 1'b0;
      end
    endcase
  end
  // Gated both-edge mode: the edge equal to the polarity level's entry only captures.
  assign reload_edge = capture_mode && capture_reload_enable && cap_edge &&
                       !(gate_enable && capture_edge_select == arct_pkg::EDGE_BOTH &&
                         (pin_polarity[0] ? rise : fall));

  // Single shot in capture mode waits for its start edge or gate removal.
  logic ss_go;
  assign ss_go = ss_armed && (ss_started || (compare_mode ? !gate_blocked : (start_edge || (gating && !gate_blocked))));

  logic running, tick, at_top, cmp_hit, cmp_in_range;
  assign running = (run_bit || ss_go) && !gate_blocked;
  assign tick    = running && (pre_cnt == 7'((1 << prescale_select) - 1));
  assign at_top  = count_value == arct_pkg::COUNT_TOP;
  assign cmp_in_range = compare >= reload;
  assign cmp_hit = compare_mode && tick && cmp_in_range && count_value == compare && !at_top;

  // Prescaler.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_cnt <= 7'h00;
    end else if (!running || tick) begin
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // Bus decode.
  logic bus_wr, bus_rd;
  assign bus_wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
  assign bus_rd = wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Counter and capture register.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_value <= arct_pkg::COUNT_RESET;
      compare     <= arct_pkg::COUNT_RESET;
    end else begin
      if (capture_mode && cap_edge && (run_bit || ss_armed)) begin
        compare <= count_value;
      end else if (bus_wr && wb_adr_in == arct_pkg::ADDR_COMPARE) begin
        compare <= merge16(compare, wb_dat_in, wb_sel_in);
      end
      if (bus_wr && wb_adr_in == arct_pkg::ADDR_COUNT) begin
        count_value <= merge16(count_value, wb_dat_in, wb_sel_in);
      end else if (reload_edge && (run_bit || ss_armed)) begin
        count_value <= reload;
      end else if (tick) begin
        count_value <= at_top ? reload : count_value + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload <= arct_pkg::COUNT_RESET;
    end else if (bus_wr && wb_adr_in == arct_pkg::ADDR_RELOAD) begin
      reload <= merge16(reload, wb_dat_in, wb_sel_in);
    end
  end

  // Single-shot end: overflow in compare mode, second start edge in capture mode.
  logic ss_end;
  assign ss_end = ss_armed && ((compare_mode && tick && at_top) ||
                               (capture_mode && ss_started && start_edge));

  // Control register with hardware clear of the single-shot bit.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= arct_pkg::CTRL_RESET;
    end else begin
      if (bus_wr && wb_adr_in == arct_pkg::ADDR_CTRL) begin
        ctrl <= {wb_sel_in[1] ? wb_dat_in[14:8] : ctrl[14:8], wb_sel_in[0] ? wb_dat_in[7:0] : ctrl[7:0]};
      end
      if (ss_end) begin
        ctrl[arct_pkg::CTRL_SSHOT] <= 1'b0;
      end
    end
  end
  assign ss_armed = single_shot_bit;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ss_started <= 1'b0;
    end else if (!ss_armed || ss_end) begin
      ss_started <= 1'b0;
    end else if (ss_go) begin
      ss_started <= 1'b1;
    end
  end

  // Flags: set wins over a software clear in the same cycle.
  logic ovf_set, cmp_set, stat_wr;
  assign ovf_set = tick && at_top;
  assign cmp_set = cmp_hit || (capture_mode && cap_edge && (run_bit || ss_armed) &&
                               !(ss_armed && !ss_started && start_edge));
  assign stat_wr = bus_wr && wb_adr_in == arct_pkg::ADDR_STATUS && wb_sel_in[0];
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overflow_flag       <= 1'b0;
      compare_status_flag <= 1'b0;
    end else begin
      if (ovf_set) begin
        overflow_flag <= 1'b1;
      end else if (stat_wr && !wb_dat_in[arct_pkg::STAT_OVF]) begin
        overflow_flag <= 1'b0;
      end
      if (cmp_set) begin
        compare_status_flag <= 1'b1;
      end else if (stat_wr && !wb_dat_in[arct_pkg::STAT_CMP]) begin
        compare_status_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_irq_out <= 1'b0;
    end else begin
      timer_irq_out <= timer_irq_enable && (overflow_flag || compare_status_flag);
    end
  end

  // Output clock: one toggle per compare match or overflow, one cycle later.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_clk <= 1'b0;
    end else if (!compare_mode) begin
      out_clk <= 1'b0;
    end else if (cmp_hit || ovf_set) begin
      out_clk <= ~out_clk;
    end
  end

  // Polarity is latched only as its enable rises, so a late write cannot glitch a live pin.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_q     <= 2'h0;
      pol_live <= 2'h0;
    end else begin
      oe_q <= pin_output_enables;
      for (int i = 0; i < 2; i++) begin
        if (pin_output_enables[i] && !oe_q[i]) begin
          pol_live[i] <= pin_polarity[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      primary_pin_out      <= 1'b0;
      primary_pin_oe_out   <= 1'b0;
      secondary_pin_out    <= 1'b0;
      secondary_pin_oe_out <= 1'b0;
    end else begin
      primary_pin_oe_out   <= compare_mode && pin_output_enables[0];
      secondary_pin_oe_out <= compare_mode && pin_output_enables[1];
      primary_pin_out      <= out_clk ^ pol_live[0];
      secondary_pin_out    <= out_clk ^ pol_live[1];
    end
  end

  // Wishbone answer: one wait state, ack for one cycle.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_wr || bus_rd;
      wb_dat_out <= 32'h0000_0000;
      if (bus_rd) begin
        case (wb_adr_in)
          arct_pkg::ADDR_CTRL:    wb_dat_out <= {17'h00000, ctrl};
          arct_pkg::ADDR_COUNT:   wb_dat_out <= {16'h0000, count_value};
          arct_pkg::ADDR_RELOAD:  wb_dat_out <= {16'h0000, reload};
          arct_pkg::ADDR_COMPARE: wb_dat_out <= {16'h0000, compare};
          arct_pkg::ADDR_STATUS:  wb_dat_out <= {28'h0000000, out_clk, timer_irq_out,
                                                 compare_status_flag, overflow_flag};
          default:                wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  chk_ovf_reload: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (tick && at_top && !bus_wr && !reload_edge) |=> count_value == $past(reload))
    else $error("counter did not reload after overflow");
  chk_ovf_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (tick && at_top) |=> overflow_flag)
    else $error("overflow flag not set");
  chk_range_match: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (compare < reload) |-> !cmp_hit)
    else $error("match signalled outside counting range");
  chk_clk_toggle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (compare_mode && (cmp_hit || ovf_set)) |=> out_clk != $past(out_clk))
    else $error("output clock failed to toggle");
  chk_pin_xor: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    primary_pin_out == ($past(out_clk) ^ $past(pol_live[0])))
    else $error("primary pin not output clock xor polarity");
  chk_gate_block: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    gate_blocked |-> !tick)
    else $error("timer ticked while gated");
  chk_sshot_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ss_end && !bus_wr) |=> !single_shot_bit)
    else $error("single shot not cleared");
  chk_capture_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    capture_mode [*2] |-> !primary_pin_oe_out && !secondary_pin_oe_out)
    else $error("pin driven in capture mode");
endmodule

// File: bench/arct_pin_model.sv
/*
  Behavioural model of the board net on the primary timer pin: it replays the
  level asked for by the bench after a chosen number of clock cycles.
  Assumes the bench changes the requested level right after a rising edge.
*/
`timescale 1ns/1ps
module arct_pin_model (
  input  wire logic       clk_in,
  input  wire logic       level_in,
  input  wire logic [3:0] lag_in,
  output logic            pin_out
);
  // A lag of zero answers promptly; larger lags stand for a slow driver.
  logic [15:0] hist;
  initial hist = 16'h0000;
  always @(posedge clk_in) begin
    hist <= {hist[14:0], level_in};
  end
  assign pin_out = (lag_in == 4'h0) ? level_in : hist[lag_in - 4'h1];
endmodule

// File: bench/arct_timer_tb_top.sv
/*
  Self-checking bench for the auto-reload capture timer: Wishbone tasks and
  scenario sequences with expected values.
  Assumes the one-cycle registered ack described for the slave.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module arct_timer_tb_top;
  logic mclk_in, rst_n_in, cyc, stb, we, ack, pin_req, pin, p0, p0_oe, p1, p1_oe, irq;
  logic [7:0] adr;
  logic [3:0] sel, lag;
  logic [31:0] dat_w, dat_r, rd, rd2;
  int mismatches, tests_run, tg;

  arct_timer #(.DUAL_PIN(1)) uut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w),
    .wb_dat_out(dat_r), .wb_ack_out(ack), .primary_pin_in(pin),
    .primary_pin_out(p0), .primary_pin_oe_out(p0_oe), .secondary_pin_out(p1),
    .secondary_pin_oe_out(p1_oe), .timer_irq_out(irq));
  arct_pin_model pm (.clk_in(mclk_in), .level_in(pin_req), .lag_in(lag), .pin_out(pin));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'h3;
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic toggles(input int n, output int c);
    logic prev;
    c = 0;
    prev = p0;
    repeat (n) begin
      @(posedge mclk_in);
      if (p0 !== prev) c++;
      prev = p0;
    end
  endtask
  task automatic setup(input logic [15:0] cmp, input logic [31:0] ctrl);
    wr(arct_pkg::ADDR_CTRL, 32'h00000000);
    wr(arct_pkg::ADDR_RELOAD, 32'h0000FFF0);
    wr(arct_pkg::ADDR_COUNT, 32'h0000FFF0);
    wr(arct_pkg::ADDR_COMPARE, {16'h0000, cmp});
    wr(arct_pkg::ADDR_STATUS, 32'h00000000);
    wr(arct_pkg::ADDR_CTRL, ctrl);
  endtask

  initial begin
    mismatches = 0; tests_run = 0;
    rst_n_in = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    dat_w = 32'h00000000; pin_req = 1'b0; lag = 4'h2;
    tick(4);
    rst_n_in <= 1'b1;
    rdr(arct_pkg::ADDR_CTRL, rd); `CHK(rd[15:0], 16'h0000)
    rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[3:0], 4'h0)
    wr(8'h40, 32'h0000ABCD);
    rdr(8'h40, rd); `CHK(rd, 32'h00000000)
    // Run, irq enable, primary output: flags, irq, wrap to reload.
    setup(16'hFFF8, 32'h00000061);
    tick(40);
    rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1:0], 2'h3)
    `CHK(irq, 1'b1)
    rdr(arct_pkg::ADDR_COUNT, rd); `CHK(rd[15:0] >= 16'hFFF0, 1'b1)
    toggles(64, tg); `CHK(tg, 8)
    `CHK(p0_oe, 1'b1)
    wr(arct_pkg::ADDR_CTRL, 32'h00000000);
    rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1:0], 2'h3)
    wr(arct_pkg::ADDR_STATUS, 32'h00000000);
    rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1:0], 2'h0)
    // Compare at the top gives one toggle there; divide by two halves the rate.
    setup(16'hFFFF, 32'h00000041);
    tick(20); toggles(64, tg); `CHK(tg, 4)
    setup(16'hFFF8, 32'h00001041);
    tick(40); toggles(64, tg); `CHK(tg, 4)
    // Compare value below the reload never matches.
    setup(16'h0010, 32'h00000001);
    tick(40);
    rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1:0], 2'h1)
    // Single shot stops at reload and clears itself; with run it keeps going.
    setup(16'hFFF8, 32'h00000042);
    tick(40);
    rdr(arct_pkg::ADDR_CTRL, rd); `CHK(rd[15:0], 16'h0040)
    rdr(arct_pkg::ADDR_COUNT, rd); tick(10); rdr(arct_pkg::ADDR_COUNT, rd2);
    `CHK(rd2, rd)
    setup(16'hFFF8, 32'h00000043);
    tick(40); toggles(64, tg); `CHK(tg, 8)
    // Polarity only lands on a rising enable.
    wr(arct_pkg::ADDR_CTRL, 32'h00000080); tick(4); rd[0] = p1;
    `CHK(p1_oe, 1'b1)
    wr(arct_pkg::ADDR_CTRL, 32'h00000280); tick(4); `CHK(p1, rd[0])
    wr(arct_pkg::ADDR_CTRL, 32'h00000000); wr(arct_pkg::ADDR_CTRL, 32'h00000280);
    tick(4); `CHK(p1, ~rd[0])
    // Gating on the primary pin, low blocks by default.
    setup(16'hFFF8, 32'h00000005); tick(4);
    rdr(arct_pkg::ADDR_COUNT, rd); tick(10); rdr(arct_pkg::ADDR_COUNT, rd2);
    `CHK(rd2, rd)
    pin_req <= 1'b1; tick(8);
    rdr(arct_pkg::ADDR_COUNT, rd2); `CHK(rd2 !== rd, 1'b1)
    setup(16'hFFF8, 32'h00000105); tick(4);
    rdr(arct_pkg::ADDR_COUNT, rd); tick(10); rdr(arct_pkg::ADDR_COUNT, rd2);
    `CHK(rd2, rd)
    pin_req <= 1'b0; lag <= 4'h6;
    setup(16'hFFF8, 32'h00000045); tick(8);
    rdr(arct_pkg::ADDR_COUNT, rd); tick(10); rdr(arct_pkg::ADDR_COUNT, rd2);
    `CHK(rd2 !== rd, 1'b1)
    // Each capture edge code, with the output enable ignored.
    for (int e = 1; e < 4; e++) begin
      setup(16'h0000, 32'h00000041 | (e << 10)); tick(12);
      `CHK(p0_oe, 1'b0)
      pin_req <= 1'b1; tick(12);
      rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1], (e != 2))
      wr(arct_pkg::ADDR_STATUS, 32'h00000000);
      pin_req <= 1'b0; tick(12);
      rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1], (e != 1))
    end
    // Capture single shot: the first rising edge starts without a flag, the next one ends it.
    setup(16'h0000, 32'h00000402);
    pin_req <= 1'b1; tick(12);
    rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1], 1'b0)
    rdr(arct_pkg::ADDR_CTRL, rd); `CHK(rd[1], 1'b1)
    pin_req <= 1'b0; tick(12);
    pin_req <= 1'b1; tick(12);
    rdr(arct_pkg::ADDR_STATUS, rd); `CHK(rd[1], 1'b1)
    rdr(arct_pkg::ADDR_CTRL, rd); `CHK(rd[1], 1'b0)
    rdr(arct_pkg::ADDR_COUNT, rd); tick(10); rdr(arct_pkg::ADDR_COUNT, rd2);
    `CHK(rd2, rd)
    pin_req <= 1'b0; tick(12);
    // Capture with reload restarts from the reload value, far from any overflow.
    setup(16'h0000, 32'h00000409);
    wr(arct_pkg::ADDR_RELOAD, 32'h00001234);
    wr(arct_pkg::ADDR_COUNT, 32'h00001000); tick(4);
    pin_req <= 1'b1; tick(10);
    rdr(arct_pkg::ADDR_COUNT, rd);
    `CHK(rd[15:0] >= 16'h1234 && rd[15:0] < 16'h1260, 1'b1)
    rdr(arct_pkg::ADDR_COMPARE, rd);
    `CHK(rd[15:0] >= 16'h1000 && rd[15:0] < 16'h1040, 1'b1)
    test_done();
  end
endmodule
